// ---- cd_defs.svh ----
`ifndef CD_DEFS_SVH
`define CD_DEFS_SVH

// Register byte addresses.
`define CD_ADDR_W 10
`define CD_DIV0_COUNTS_ADDR 10'h190
`define CD_DIV0_CONTROL_ADDR 10'h191
`define CD_CH0_POWER_ADDR 10'h192
`define CD_DIV1_COUNTS_ADDR 10'h193
`define CD_DIV1_CONTROL_ADDR 10'h194
`define CD_CH1_POWER_ADDR 10'h195

// Cycle count fields.
`define CD_LOW_MSB 7
`define CD_LOW_LSB 4
`define CD_HIGH_MSB 3
`define CD_HIGH_LSB 0

// Control fields.
`define CD_BYPASS_BIT 7
`define CD_IGNORE_BIT 6
`define CD_FORCE_BIT 5
`define CD_START_BIT 4
`define CD_PHASE_MSB 3
`define CD_PHASE_LSB 0

// Power and duty fields; other bits of that register read zero.
`define CD_PDN_BIT 2
`define CD_DCC_DIS_BIT 0
`define CD_POWER_MASK 8'h05

// Reset values.
`define CD_DIV0_COUNTS_RST 8'h77
`define CD_DIV1_COUNTS_RST 8'h33
`define CD_CONTROL_RST 8'h00
`define CD_POWER_RST 8'h00

// Total period offset: both phases add one cycle each.
`define CD_PERIOD_EXTRA 6'h02
`endif

// ---- cd_pkg.sv ----
package cd_pkg;
  // Divider sequencing: held by sync, waiting out the phase offset, running.
  typedef enum logic [1:0] {
    CD_HOLD,
    CD_DELAY,
    CD_RUN
  } cd_state_t;

  // One configuration register byte.
  typedef logic [7:0] cd_byte_t;
endpackage

// ---- cd_out_stage.sv ----
`timescale 1ns/100ps
// One output pin of a channel: power-down enable and bypass selection.
module cd_out_stage (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic div_in,
  input wire logic bypass_in,
  input wire logic pdn_in,
  output logic pin_out,
  output logic pin_en_out
);
  // Registered enable, high while the pin is driven.
  logic en_reg;
  // Registered bypass select, so the mux select never glitches.
  logic byp_reg;

  // Power-down takes the pin to high impedance by dropping its enable.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= ~pdn_in;
    end
  end

  // The bypass select is captured on the clock so it changes cleanly.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byp_reg <= 1'b0;
    end else begin
      byp_reg <= bypass_in;
    end
  end

  // In bypass the input clock itself reaches the pin; this is the one
  // path that cannot come from a flip-flop, since it is divide by one.
  // A powered-down pin drives a quiet low behind its low enable.
  assign pin_out = en_reg & (byp_reg ? ref_clk_in : div_in);
  assign pin_en_out = en_reg;
endmodule

// ---- cd_top.sv ----
`timescale 1ns/100ps
`include "cd_defs.svh"
// Two channel clock dividers with their configuration registers.
// Register writes land on the edge that samples the strobe; reads
// load their data on that same edge and then hold until the next read.
module cd_top #(
  parameter int COUNT_W = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Chip-level synchronization, active high, held as a level.
  input wire logic sync_in,
  // Register access port. Both strobes last one cycle per byte; a read
  // and a write in one cycle return the old value.
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  // Byte address; only the six channel registers answer.
  input wire logic [`CD_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Registered read data, held until the next read.
  output logic [7:0] reg_rdata_out,
  // Channel 0 outputs and their enables.
  output logic channel0_output_a_out,
  output logic channel0_output_b_out,
  output logic channel0_output_c_out,
  output logic channel0_output_a_en_out,
  output logic channel0_output_b_en_out,
  output logic channel0_output_c_en_out,
  // Channel 1 outputs and their enables.
  output logic channel1_output_a_out,
  output logic channel1_output_b_out,
  output logic channel1_output_c_out,
  output logic channel1_output_a_en_out,
  output logic channel1_output_b_en_out,
  output logic channel1_output_c_en_out
);
  // Both count fields must share one register byte.
  // Wider fields would need a second register byte per channel.
  if (2 * COUNT_W != 8) begin : g_bad_width
    $error("COUNT_W must be 4 so both counts fit one byte.");
  end

  // Number of channels and of outputs per channel.
  // The loops serve any count; the pin maps below are written out.
  localparam int NCH = 2;
  localparam int NOUT = 3;

  // Addresses of each channel's three registers.
  localparam logic [`CD_ADDR_W-1:0] CNT_ADDR [NCH] = '{
    `CD_DIV0_COUNTS_ADDR, `CD_DIV1_COUNTS_ADDR};
  localparam logic [`CD_ADDR_W-1:0] CTL_ADDR [NCH] = '{
    `CD_DIV0_CONTROL_ADDR, `CD_DIV1_CONTROL_ADDR};
  localparam logic [`CD_ADDR_W-1:0] PWR_ADDR [NCH] = '{
    `CD_CH0_POWER_ADDR, `CD_CH1_POWER_ADDR};
  // The two dividers come out of reset at different ratios.
  localparam cd_pkg::cd_byte_t CNT_RST [NCH] = '{
    `CD_DIV0_COUNTS_RST, `CD_DIV1_COUNTS_RST};

  // Channel state lives in arrays so one loop serves both channels.
  // Low and high cycle counts, one byte per channel.
  cd_pkg::cd_byte_t counts_reg [NCH];
  // Bypass, ignore sync, force, start level and phase offset.
  cd_pkg::cd_byte_t control_reg [NCH];
  // Power-down and duty-cycle correction disable.
  cd_pkg::cd_byte_t power_reg [NCH];
  // Registered read data.
  cd_pkg::cd_byte_t rdata_reg;
  // Read data for the addressed register.
  cd_pkg::cd_byte_t rdata_next;
  // Divider output level of each channel, from a flip-flop.
  logic [NCH-1:0] div_reg;
  // Pin outputs and enables, channel by output.
  logic pin [NCH][NOUT];
  logic pin_en [NCH][NOUT];

  // Read mux: unmapped addresses read zero. The addresses never overlap,
  // so the order of the tests below does not matter.
  always_comb begin
    rdata_next = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (reg_addr_in == CNT_ADDR[c]) begin
        rdata_next = counts_reg[c];
      end
      if (reg_addr_in == CTL_ADDR[c]) begin
        rdata_next = control_reg[c];
      end
      if (reg_addr_in == PWR_ADDR[c]) begin
        // Reserved bits are never stored, so they read zero.
        rdata_next = power_reg[c];
      end
    end
  end

  // Read data is taken one cycle after the read strobe and held.
  // Holding it lets a slow reader sample at leisure; the cost is one
  // flop per bit and one cycle of latency.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_in) begin
      // Only a read strobe moves the read data.
      rdata_reg <= rdata_next;
    end
  end

  // The read port comes straight from its flop.
  assign reg_rdata_out = rdata_reg;

  // One divider per channel; both share the bus and the sync input, so
  // channels released together leave hold on the same edge.
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Sequencer state of this channel.
    cd_pkg::cd_state_t state_reg;
    // Cycle counter shared by the phase delay and both phases.
    logic [COUNT_W-1:0] cnt_reg;
    // Internal divider level before any forcing.
    logic lvl_reg;
    // Field views of the registers.
    logic [COUNT_W-1:0] low_cnt;
    logic [COUNT_W-1:0] high_cnt;
    logic [COUNT_W-1:0] phase;
    // Control bits of this channel.
    logic bypass;
    logic ignore_sync;
    logic force_hi;
    logic start_hi;
    // Power and duty bits of this channel.
    logic pdn;
    logic dcc_dis;
    // Whole period in cycles and the per-phase limits derived from it.
    logic [5:0] period;
    logic [5:0] half_up;
    logic [5:0] half_dn;
    logic [COUNT_W-1:0] high_lim;
    logic [COUNT_W-1:0] low_lim;
    logic [COUNT_W-1:0] cur_lim;
    // Sync is obeyed only while the ignore bit is clear.
    logic sync_hold;

    // Slices of the three registers; every field sits at fixed bits.
    assign low_cnt = counts_reg[c][`CD_LOW_MSB:`CD_LOW_LSB];
    assign high_cnt = counts_reg[c][`CD_HIGH_MSB:`CD_HIGH_LSB];
    assign bypass = control_reg[c][`CD_BYPASS_BIT];
    assign ignore_sync = control_reg[c][`CD_IGNORE_BIT];
    assign force_hi = control_reg[c][`CD_FORCE_BIT];
    assign start_hi = control_reg[c][`CD_START_BIT];
    assign phase = control_reg[c][`CD_PHASE_MSB:`CD_PHASE_LSB];
    assign pdn = power_reg[c][`CD_PDN_BIT];
    assign dcc_dis = power_reg[c][`CD_DCC_DIS_BIT];

    // Counts register: write at its address. A new count is compared
    // live, so it acts within the current level; a counter already past
    // the new limit runs on until it wraps, which stretches one level.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        counts_reg[c] <= CNT_RST[c];
      end else if (reg_wr_in && reg_addr_in == CNT_ADDR[c]) begin
        counts_reg[c] <= reg_wdata_in;
      end
    end

    // Control register: phase offset resets to zero with the rest.
    // A new start level or offset only takes hold at the next sync or bypass release.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        control_reg[c] <= `CD_CONTROL_RST;
      end else if (reg_wr_in && reg_addr_in == CTL_ADDR[c]) begin
        control_reg[c] <= reg_wdata_in;
      end
    end

    // Power and duty register: only the two defined bits are kept.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        power_reg[c] <= `CD_POWER_RST;
      end else if (reg_wr_in && reg_addr_in == PWR_ADDR[c]) begin
        // Masking on write keeps the unused bits at zero with no read logic.
        power_reg[c] <= reg_wdata_in & `CD_POWER_MASK;
      end
    end

    // The period is the sum of both phases, each one longer than its
    // field. Correction splits that period as evenly as whole input
    // cycles allow; odd periods give the extra cycle to the high phase,
    // since half-cycle steps are not available in this clock domain.
    always_comb begin
      // Six bits hold the longest period of thirty-two cycles.
      period = {2'b00, high_cnt} + {2'b00, low_cnt} + `CD_PERIOD_EXTRA;
      half_up = (period + 6'h01) >> 1;
      half_dn = period >> 1;
      // Without correction each phase keeps its own field.
      if (dcc_dis) begin
        high_lim = high_cnt;
        low_lim = low_cnt;
      end else begin
        // With correction both limits come from the even split.
        high_lim = 4'(half_up - 6'h01);
        low_lim = 4'(half_dn - 6'h01);
      end
      // The counter is held against the limit of the level it is in.
      cur_lim = lvl_reg ? high_lim : low_lim;
    end

    // Sync is a level: with ignore clear the divider stays parked while it is high.
    assign sync_hold = sync_in & ~ignore_sync;

    // Divider sequencer. Sync or bypass parks it at the start level; on
    // release it waits out the phase offset, then alternates phases.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        // Reset parks the divider; its release acts like a sync release.
        state_reg <= cd_pkg::CD_HOLD;
        cnt_reg <= '0;
        lvl_reg <= 1'b0;
      end else if (bypass || sync_hold) begin
        // Bypass powers the divider down; it restarts when cleared.
        state_reg <= cd_pkg::CD_HOLD;
        cnt_reg <= '0;
        lvl_reg <= start_hi;
      end else begin
        case (state_reg)
          cd_pkg::CD_HOLD: begin
            // First free cycle: load the start level, clear the counter.
            state_reg <= cd_pkg::CD_DELAY;
            cnt_reg <= '0;
            lvl_reg <= start_hi;
          end
          cd_pkg::CD_DELAY: begin
            // A zero offset leaves only the one cycle of this state.
            if (cnt_reg == phase) begin
              state_reg <= cd_pkg::CD_RUN;
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          cd_pkg::CD_RUN: begin
            // Each level lasts its limit plus one cycles.
            if (cnt_reg == cur_lim) begin
              lvl_reg <= ~lvl_reg;
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          default: begin
            // An unused state code recovers through hold.
            state_reg <= cd_pkg::CD_HOLD;
            cnt_reg <= '0;
          end
        endcase
      end
    end

    // Output flop. Force only acts with ignore set; otherwise the force
    // bit is inert and the divider level passes through. The flop keeps
    // the divider path free of glitches, at the price of one cycle of
    // latency after the sequencer.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        div_reg[c] <= 1'b0;
      end else if (ignore_sync && force_hi) begin
        // Ignore with force pins the output high.
        div_reg[c] <= 1'b1;
      end else begin
        div_reg[c] <= lvl_reg;
      end
    end

    // Three pins per channel share the divider and power state. Each pin
    // has its own enable and select flops; the divider flop div_reg and the
    // register bits pdn and bypass each drive all three loads.
    for (genvar o = 0; o < NOUT; o++) begin : g_out
      cd_out_stage u_stage (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .div_in(div_reg[c]),
        .bypass_in(bypass),
        .pdn_in(pdn),
        .pin_out(pin[c][o]),
        .pin_en_out(pin_en[c][o])
      );
    end
  end

  // Pin map of channel 0.
  // Each top-level pin is a named copy of its stage's output.
  assign channel0_output_a_out = pin[0][0];
  assign channel0_output_b_out = pin[0][1];
  assign channel0_output_c_out = pin[0][2];
  assign channel0_output_a_en_out = pin_en[0][0];
  assign channel0_output_b_en_out = pin_en[0][1];
  assign channel0_output_c_en_out = pin_en[0][2];

  // Pin map of channel 1.
  // Channel 1 keeps the same pin order as channel 0.
  assign channel1_output_a_out = pin[1][0];
  assign channel1_output_b_out = pin[1][1];
  assign channel1_output_c_out = pin[1][2];
  assign channel1_output_a_en_out = pin_en[1][0];
  assign channel1_output_b_en_out = pin_en[1][1];
  assign channel1_output_c_en_out = pin_en[1][2];
endmodule

// ---- cd_sink_model.sv ----
`timescale 1ns/100ps
// Clock sink on one channel pin: measures the last high and low runs.
module cd_sink_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic [7:0] hi_len_out,
  output logic [7:0] lo_len_out,
  output logic [15:0] edges_out
);
  logic [7:0] run_reg; // Edges seen at the current level.
  logic last_reg; // Level seen at the previous edge.
  // A run closes when the level changes. The input has a pull-down, so a
  // floating pin reads low here and ends a high run like a real sink would.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_reg <= 8'h01;
      last_reg <= 1'b0;
      hi_len_out <= 8'h00;
      lo_len_out <= 8'h00;
      edges_out <= 16'h0000;
    end else if (pin_in !== last_reg) begin
      if (last_reg) hi_len_out <= run_reg;
      else lo_len_out <= run_reg;
      run_reg <= 8'h01;
      last_reg <= pin_in;
      edges_out <= edges_out + 16'h0001;
    end else begin
      run_reg <= run_reg + 8'h01;
    end
  end
endmodule

// ---- cd_top_asserts.sv ----
`timescale 1ns/100ps
`include "cd_defs.svh"
// Port-level checks of the divider block; reads of bus and pins only.
module cd_top_asserts #(
  parameter int COUNT_W = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`CD_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic channel0_output_a_out,
  input wire logic channel0_output_b_out,
  input wire logic channel0_output_c_out,
  input wire logic channel0_output_a_en_out,
  input wire logic channel0_output_b_en_out,
  input wire logic channel0_output_c_en_out,
  input wire logic channel1_output_a_out,
  input wire logic channel1_output_b_out,
  input wire logic channel1_output_c_out,
  input wire logic channel1_output_a_en_out,
  input wire logic channel1_output_b_en_out,
  input wire logic channel1_output_c_en_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  pdn_float_a: assert property (
    reg_wr_in && reg_addr_in == `CD_CH0_POWER_ADDR && reg_wdata_in[2]
    |-> ##[1:3] !channel0_output_a_en_out)
    else $error("power-down left channel 0 driving");
  pdn_pin_low_a: assert property (
    !channel0_output_a_en_out |-> !channel0_output_a_out)
    else $error("floating pin not held low");
  ch0_match_a: assert property (
    channel0_output_a_out == channel0_output_b_out &&
    channel0_output_b_out == channel0_output_c_out &&
    channel0_output_a_en_out == channel0_output_c_en_out &&
    channel0_output_b_en_out == channel0_output_c_en_out)
    else $error("channel 0 pins differ");
  ch1_match_a: assert property (
    channel1_output_a_out == channel1_output_b_out &&
    channel1_output_b_out == channel1_output_c_out &&
    channel1_output_a_en_out == channel1_output_c_en_out &&
    channel1_output_b_en_out == channel1_output_c_en_out)
    else $error("channel 1 pins differ");
  unmapped_zero_a: assert property (reg_rd_in &&
    (reg_addr_in < `CD_DIV0_COUNTS_ADDR || reg_addr_in > `CD_CH1_POWER_ADDR)
    |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  power_mask_a: assert property (
    reg_rd_in && reg_addr_in == `CD_CH0_POWER_ADDR
    |=> (reg_rdata_out & ~`CD_POWER_MASK) == 8'h00)
    else $error("power register shows unused bits");
  count_store_a: assert property (
    reg_wr_in && reg_addr_in == `CD_DIV0_COUNTS_ADDR ##2
    reg_rd_in && !reg_wr_in && reg_addr_in == `CD_DIV0_COUNTS_ADDR
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("count register lost its value");
  pdn_c: cover property (!channel0_output_a_en_out);
  toggle_c: cover property ($rose(channel1_output_a_out));
  unmapped_c: cover property (reg_rd_in && reg_addr_in > 10'h195);
endmodule
bind cd_top cd_top_asserts #(.COUNT_W(COUNT_W)) i_cd_top_asserts (.*);

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  typedef struct {logic wr; logic [9:0] addr; logic [7:0] wd, ex;} cd_row_t;
  logic ref_clk_in = 0, rst_b_in = 0, sync_in = 0;
  logic reg_wr_in = 0, reg_rd_in = 0;
  logic [9:0] reg_addr_in = 10'h000;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, rd_val;
  logic a0, b0, c0, ea0, eb0, ec0, a1, b1, c1, ea1, eb1, ec1;
  logic [7:0] hi0, lo0, hi1, lo1;
  logic [15:0] ed0, ed1, e0;
  int fails = 0, compares = 0, cycles = 0, n;
  // Reset reads first, then writes read back, unused bits and a dead address.
  cd_row_t rows [16] = '{'{0, 10'h190, 8'h00, 8'h77},
    '{0, 10'h191, 8'h00, 8'h00}, '{0, 10'h192, 8'h00, 8'h00},
    '{0, 10'h193, 8'h00, 8'h33}, '{0, 10'h194, 8'h00, 8'h00},
    '{0, 10'h195, 8'h00, 8'h00}, '{0, 10'h3FF, 8'h00, 8'h00},
    '{1, 10'h190, 8'hA5, 8'hA5}, '{1, 10'h190, 8'h77, 8'h77},
    '{1, 10'h192, 8'hFF, 8'h05}, '{1, 10'h192, 8'h00, 8'h00},
    '{1, 10'h194, 8'h5F, 8'h5F}, '{1, 10'h194, 8'h00, 8'h00},
    '{1, 10'h195, 8'hFF, 8'h05}, '{1, 10'h195, 8'h00, 8'h00},
    '{1, 10'h3FF, 8'h55, 8'h00}};
  cd_top i_cd_top (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .sync_in(sync_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .channel0_output_a_out(a0),
    .channel0_output_b_out(b0), .channel0_output_c_out(c0),
    .channel0_output_a_en_out(ea0), .channel0_output_b_en_out(eb0),
    .channel0_output_c_en_out(ec0), .channel1_output_a_out(a1),
    .channel1_output_b_out(b1), .channel1_output_c_out(c1),
    .channel1_output_a_en_out(ea1), .channel1_output_b_en_out(eb1),
    .channel1_output_c_en_out(ec1));
  // The sinks see the wire, which a pull-down holds low when released.
  cd_sink_model i_sink0 (.clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pin_in(ea0 ? a0 : 1'b0), .hi_len_out(hi0), .lo_len_out(lo0),
    .edges_out(ed0));
  cd_sink_model i_sink1 (.clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .pin_in(ea1 ? a1 : 1'b0), .hi_len_out(hi1), .lo_len_out(lo1),
    .edges_out(ed1));
  // Free-running 40 MHz divider input clock.
  initial begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  // Guards against a hang; the run needs well under 3000 cycles.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [15:0] ex, got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, ex, got);
    end
  endtask
  // One-cycle write strobe, raised and dropped 2 ns after the edge.
  task automatic wr(input logic [9:0] ad, input logic [7:0] d);
    @(posedge ref_clk_in);
    #2 reg_wr_in = 1;
    reg_addr_in = ad;
    reg_wdata_in = d;
    @(posedge ref_clk_in);
    #2 reg_wr_in = 0;
  endtask
  // Read data is taken one edge after the strobe edge; it then holds.
  task automatic rd(input logic [9:0] ad);
    @(posedge ref_clk_in);
    #2 reg_rd_in = 1;
    reg_addr_in = ad;
    @(posedge ref_clk_in);
    #2 reg_rd_in = 0;
    @(posedge ref_clk_in);
    #1 rd_val = reg_rdata_out;
  endtask
  // Holds the divider in sync, releases it, counts edges to the first change.
  task automatic sync_run(input logic [7:0] ctl, input logic lvl, int ex);
    wr(10'h191, ctl);
    sync_in = 1;
    repeat (30) @(posedge ref_clk_in);
    #2 check("held level", lvl, a0);
    sync_in = 0;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1 n++;
    end while (a0 === lvl && n < 60);
    check("first change edge", 16'(ex), 16'(n));
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #2 rst_b_in = 1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wd);
      rd(rows[i].addr);
      check("register", rows[i].ex, rd_val);
    end
    repeat (60) @(posedge ref_clk_in);
    check("ch0 high run", 8, hi0);
    check("ch0 low run", 8, lo0);
    check("ch1 runs", 16'h0404, {hi1, lo1});
    sync_run(8'h03, 0, 14);
    sync_run(8'h0F, 0, 26);
    sync_run(8'h10, 1, 11);
    wr(10'h191, 8'h40);
    sync_in = 1;
    e0 = ed0;
    repeat (40) @(posedge ref_clk_in);
    check("runs while ignored", 1, ed0 != e0);
    wr(10'h191, 8'h60);
    repeat (4) @(posedge ref_clk_in);
    e0 = ed0;
    repeat (20) @(posedge ref_clk_in);
    check("forced edges", 16'h0000, ed0 - e0);
    check("forced high", 16'h0001, a0);
    wr(10'h191, 8'h80);
    sync_in = 0;
    repeat (3) @(posedge ref_clk_in);
    #5 check("bypass high", 1, a0);
    @(negedge ref_clk_in);
    #5 check("bypass low", 0, a0);
    wr(10'h191, 8'h00);
    wr(10'h192, 8'h04);
    repeat (3) @(posedge ref_clk_in);
    #1 check("floated", 0, {ea0, eb0, ec0, a0});
    check("other channel", 1, ea1);
    wr(10'h192, 8'h01);
    wr(10'h190, 8'h52);
    repeat (50) @(posedge ref_clk_in);
    check("raw runs", 16'h0306, {hi0, lo0});
    wr(10'h192, 8'h00);
    repeat (50) @(posedge ref_clk_in);
    check("corrected runs", 16'h0504, {hi0, lo0});
    // Reset in mid-run: pins stop, read data clears, counts come back.
    #2 rst_b_in = 0;
    #1 check("reset pins", 0, {ea0, a0, ea1, reg_rdata_out});
    repeat (16) @(posedge ref_clk_in);
    #2 rst_b_in = 1;
    rd(10'h190);
    check("counts after reset", 16'h0077, rd_val);
    stop_test();
  end
endmodule
